// *** hdl/pot_serial_command_decoder.sv ***
// Serial command decoder and wiper/nonvolatile store for a digital potentiometer
//
// Behaviour
// - 24-bit MSB-first: command, location, sixteen data
// - Bare chip-select pulse repeats previous command
// - Count not multiple of four: drop word
// - Execute only after chip select returns high
// - Command 0 clears read-program, nothing else
// - Command 1: restore location 0, read-program
// - Command 2: store wiper to location 0
// - Command 3: store data to addressed location
// - Location 0 uses low ten bits
// - Commands 4, 5: halve the wiper
// - Commands 6, 7: wiper down one step
// - Command 8: reload wiper from location 0
// - Command 9: addressed location read next frame
// - Command 10: wiper read next frame
// - Command 11: load wiper from data
// - Commands 12, 13: double the wiper
// - Commands 14, 15: wiper up one step
// - Data out repeats input one frame later
// - Read data replaces outgoing data bytes
// - Wiper reloaded from location 0 at power-on
// - Step and shift commands ignore data
`timescale 1ns/1ps
`include "pot_map.svh"

module pot_serial_command_decoder (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output pot_pkg::wiper_t wiper_register,
  output logic read_program_state,
  output logic serial_out_line_o,
  output logic serial_out_line_oe,
  output logic frame_dropped,
  output logic command_done
);
  import pot_pkg::*;

  ctl_state_t cur;
  ctl_state_t next_cur;

  // Nonvolatile store survives sys_rst, so it sits outside the state struct
  // Factory content in every word, loaded once and not by sys_rst
  nv_word_t nonvolatile_store [0:`NV_DEPTH-1] = '{default: `NV_DEFAULT};
  logic store_we;
  logic [`ADDR_W-1:0] store_addr;
  nv_word_t store_wdata;

  logic cs_sync_n;
  logic link_rst;
  frame_t link_word;
  bit_count_t link_count;
  logic link_sdo;

  bit_count_t frame_bits;
  cmd_t cmd;
  logic [`ADDR_W-1:0] addr;
  nv_word_t data;
  logic addr_ok;

  // Left shift with the zero and upper-half corners
  function automatic wiper_t shift_up(input wiper_t w);
    if (w == `WIPER_ZERO) begin
      shift_up = `WIPER_ONE;
    end else if (w >= `WIPER_MID) begin
      shift_up = `WIPER_FULL;
    end else begin
      shift_up = {w[`WIPER_HI-1:0], 1'b0};
    end
  endfunction : shift_up

  // One position up or down without wrap
  function automatic wiper_t step_one(input wiper_t w, input logic up);
    if (up) begin
      step_one = (w == `WIPER_FULL) ? w : w + `WIPER_ONE;
    end else begin
      step_one = (w == `WIPER_ZERO) ? w : w - `WIPER_ONE;
    end
  endfunction : step_one

  // Codes whose location field must be zero to act
  function automatic logic needs_zero_addr(input cmd_t c);
    case (c)
      CMD_RESTORE, CMD_STORE_WIPER, CMD_SHR_ADDR, CMD_DEC_ADDR, CMD_READ_WIPER,
      CMD_WRITE_WIPER, CMD_SHL_ADDR, CMD_INC_ADDR: begin
        needs_zero_addr = 1'b1;
      end
      default: begin
        needs_zero_addr = 1'b0;
      end
    endcase
  endfunction : needs_zero_addr

  level_sync cs_sync (
    .clock(clock),
    .d(chip_select_n),
    .q(cs_sync_n)
  );

  // Link side needs edges during sys_rst to clear its counter
  level_sync rst_sync (
    .clock(link_clock),
    .d(sys_rst),
    .q(link_rst)
  );

  link_shifter link (
    .link_clock(link_clock),
    .link_rst(link_rst),
    .chip_select_n(chip_select_n),
    .serial_in(serial_in),
    .base(cur.base),
    .rd_valid(cur.rd_valid),
    .rd_data(cur.rd_data),
    .word(link_word),
    .count(link_count),
    .serial_out_bit(link_sdo)
  );

  always_comb begin
    next_cur = cur;
    store_we = 1'b0;
    store_addr = '0;
    store_wdata = '0;
    frame_bits = link_count - cur.base;
    cmd = cmd_t'(cur.cmd_word[`CMD_HI:`CMD_LO]);
    addr = cur.cmd_word[`ADDR_HI:`ADDR_LO];
    data = cur.cmd_word[`DATA_HI:`DATA_LO];
    addr_ok = !needs_zero_addr(cmd) || (addr == '0);
    next_cur.cs_prev_n = cs_sync_n;
    next_cur.sdo_oe = !cs_sync_n;
    next_cur.frame_dropped = 1'b0;
    next_cur.cmd_done = 1'b0;
    case (cur.state)
      ST_POWER_UP: begin
        next_cur.wiper = nonvolatile_store[0][`WIPER_HI:0];
        next_cur.state = ST_IDLE;
      end
      ST_IDLE: begin
        // Word is steady: the link clock is idle once chip select is high
        if (cs_sync_n && !cur.cs_prev_n) begin
          next_cur.base = link_count;
          if (frame_bits[1:0] != 2'b00) begin
            next_cur.frame_dropped = 1'b1;
          end else if (frame_bits == '0) begin
            // Nothing to repeat before the first command after power-up
            if (cur.have_cmd) begin
              next_cur.state = ST_EXEC;
            end
          end else begin
            next_cur.cmd_word = link_word;
            next_cur.have_cmd = 1'b1;
            next_cur.state = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        next_cur.state = ST_IDLE;
        next_cur.cmd_done = 1'b1;
        // Readback lasts until the next executed command; a dropped frame does not clear it
        next_cur.rd_valid = 1'b0;
        if (addr_ok) begin
          case (cmd)
            CMD_NOP: begin
              next_cur.read_program = 1'b0;
            end
            CMD_RESTORE: begin
              next_cur.wiper = nonvolatile_store[0][`WIPER_HI:0];
              next_cur.read_program = 1'b1;
            end
            CMD_STORE_WIPER: begin
              store_we = 1'b1;
              store_addr = '0;
              store_wdata = {6'h00, cur.wiper};
            end
            CMD_STORE_NV: begin
              store_we = 1'b1;
              store_addr = addr;
              store_wdata = data;
            end
            CMD_SHR_ADDR, CMD_SHR: begin
              next_cur.wiper = {1'b0, cur.wiper[`WIPER_HI:1]};
            end
            CMD_DEC_ADDR, CMD_DEC: begin
              next_cur.wiper = step_one(cur.wiper, 1'b0);
            end
            CMD_RESET: begin
              next_cur.wiper = nonvolatile_store[0][`WIPER_HI:0];
            end
            CMD_READ_NV: begin
              next_cur.rd_data = nonvolatile_store[addr];
              next_cur.rd_valid = 1'b1;
            end
            CMD_READ_WIPER: begin
              next_cur.rd_data = {6'h00, cur.wiper};
              next_cur.rd_valid = 1'b1;
            end
            CMD_WRITE_WIPER: begin
              next_cur.wiper = data[`WIPER_HI:0];
            end
            CMD_SHL_ADDR, CMD_SHL: begin
              next_cur.wiper = shift_up(cur.wiper);
            end
            CMD_INC_ADDR, CMD_INC: begin
              next_cur.wiper = step_one(cur.wiper, 1'b1);
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur <= '{state: ST_POWER_UP, cs_prev_n: 1'b1, wiper: `WIPER_ZERO,
               read_program: 1'b0, have_cmd: 1'b0, cmd_word: '0, base: '0,
               rd_valid: 1'b0, rd_data: '0, sdo_oe: 1'b0, frame_dropped: 1'b0,
               cmd_done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  always_ff @(posedge clock) begin
    if (store_we) begin
      nonvolatile_store[store_addr] <= store_wdata;
    end
  end

  assign wiper_register = cur.wiper;
  assign read_program_state = cur.read_program;
  // Enable follows chip select a few clocks late; host samples mid-frame only
  assign serial_out_line_oe = cur.sdo_oe;
  assign serial_out_line_o = link_sdo;
  assign frame_dropped = cur.frame_dropped;
  assign command_done = cur.cmd_done;

endmodule : pot_serial_command_decoder

// *** include/pot_map.svh ***
// Constants for the potentiometer serial command decoder
`ifndef POT_MAP_SVH
`define POT_MAP_SVH

`define FRAME_BITS 24
`define CMD_W 4
`define ADDR_W 4
`define DATA_W 16
`define WIPER_W 10
`define CNT_W 8
`define NV_DEPTH 16

`define CMD_HI 23
`define CMD_LO 20
`define ADDR_HI 19
`define ADDR_LO 16
`define DATA_HI 15
`define DATA_LO 0
`define WIPER_HI 9

`define RD_FIRST_POS 8'h08
`define RD_LAST_POS 8'h17
`define RD_TOP_POS 5'h17

`define WIPER_ZERO 10'h000
`define WIPER_ONE 10'h001
`define WIPER_MID 10'h200
`define WIPER_FULL 10'h3ff
`define NV_DEFAULT 16'h0200

`endif

// *** include/pot_pkg.sv ***
// Types shared by the potentiometer serial command decoder
`include "pot_map.svh"

package pot_pkg;

  typedef logic [`WIPER_W-1:0] wiper_t;
  typedef logic [`DATA_W-1:0] nv_word_t;
  typedef logic [`CNT_W-1:0] bit_count_t;
  typedef logic [`FRAME_BITS-1:0] frame_t;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_RESTORE = 4'h1,
    CMD_STORE_WIPER = 4'h2,
    CMD_STORE_NV = 4'h3,
    CMD_SHR_ADDR = 4'h4,
    CMD_SHR = 4'h5,
    CMD_DEC_ADDR = 4'h6,
    CMD_DEC = 4'h7,
    CMD_RESET = 4'h8,
    CMD_READ_NV = 4'h9,
    CMD_READ_WIPER = 4'ha,
    CMD_WRITE_WIPER = 4'hb,
    CMD_SHL_ADDR = 4'hc,
    CMD_SHL = 4'hd,
    CMD_INC_ADDR = 4'he,
    CMD_INC = 4'hf
  } cmd_t;

  typedef enum logic [2:0] {
    ST_POWER_UP = 3'h1,
    ST_IDLE = 3'h2,
    ST_EXEC = 3'h4
  } state_t;

  typedef struct packed {
    state_t state;
    logic cs_prev_n;
    wiper_t wiper;
    logic read_program;
    logic have_cmd;
    frame_t cmd_word;
    bit_count_t base;
    logic rd_valid;
    nv_word_t rd_data;
    logic sdo_oe;
    logic frame_dropped;
    logic cmd_done;
  } ctl_state_t;

  typedef struct packed {
    frame_t sreg;
    bit_count_t count;
    logic serial_out_line;
  } link_state_t;

  typedef struct packed {
    logic meta;
    logic q;
  } sync_state_t;

endpackage : pot_pkg

// *** hdl/level_sync.sv ***
// Two-flop synchroniser for a single level
`timescale 1ns/1ps

module level_sync (
  input wire logic clock,
  input wire logic d,
  output logic q
);
  import pot_pkg::*;

  sync_state_t cur;
  sync_state_t next_cur;

  // First flop feeds only the second
  always_comb begin
    next_cur.meta = d;
    next_cur.q = cur.meta;
  end

  always_ff @(posedge clock) begin
    cur <= next_cur;
  end

  assign q = cur.q;

endmodule : level_sync

// *** hdl/link_shifter.sv ***
// Serial shift register, bit counter and data-out bit on the link clock
`timescale 1ns/1ps
`include "pot_map.svh"

module link_shifter (
  input wire logic link_clock,
  input wire logic link_rst,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire pot_pkg::bit_count_t base,
  input wire logic rd_valid,
  input wire pot_pkg::nv_word_t rd_data,
  output pot_pkg::frame_t word,
  output pot_pkg::bit_count_t count,
  output logic serial_out_bit
);
  import pot_pkg::*;

  link_state_t cur;
  link_state_t next_cur;
  bit_count_t pos;
  logic [4:0] rd_idx;

  always_comb begin
    next_cur = cur;
    pos = '0;
    rd_idx = '0;
    if (!chip_select_n) begin
      // MSB first, newest bit at the bottom
      next_cur.sreg = {cur.sreg[`FRAME_BITS-2:0], serial_in};
      next_cur.count = cur.count + 8'h01;
      // Base only moves between frames, so it is steady here
      pos = next_cur.count - base;
      rd_idx = `RD_TOP_POS - pos[4:0];
      if (rd_valid && pos >= `RD_FIRST_POS && pos <= `RD_LAST_POS) begin
        next_cur.serial_out_line = rd_data[rd_idx[3:0]];
      end else begin
        // Bit clocked in one frame ago
        next_cur.serial_out_line = next_cur.sreg[`FRAME_BITS-1];
      end
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign word = cur.sreg;
  assign count = cur.count;
  assign serial_out_bit = cur.serial_out_line;

endmodule : link_shifter

// *** bench/pot_chk.sv ***
// Port assertions for the potentiometer command decoder
`timescale 1ns/1ps
module pot_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire pot_pkg::wiper_t wiper_register,
  input wire logic read_program_state,
  input wire logic serial_out_line_o,
  input wire logic serial_out_line_oe,
  input wire logic frame_dropped,
  input wire logic command_done
);
  import pot_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_done_one_cycle: assert property (command_done |=> !command_done)
    else $error("command done wider than one cycle");
  a_drop_one_cycle: assert property (frame_dropped |=> !frame_dropped)
    else $error("frame dropped wider than one cycle");
  a_drop_no_exec: assert property (frame_dropped |-> !command_done ##1 $stable(wiper_register))
    else $error("dropped frame executed");
  a_exec_after_cs: assert property (command_done |-> chip_select_n && $past(chip_select_n, 3))
    else $error("command executed inside a frame");
  a_drop_after_cs: assert property (frame_dropped |-> $past(chip_select_n, 2))
    else $error("frame dropped inside a frame");
  // Power-up reload lands one edge after release, so look back four
  a_wiper_cause: assert property (($changed(wiper_register) && !$past(sys_rst, 3)
    && !$past(sys_rst, 4)) |-> command_done)
    else $error("wiper moved without a command");
  a_oe_idle: assert property (chip_select_n [*4] |-> !serial_out_line_oe)
    else $error("data out driven between frames");
  a_sdo_hold: assert property (chip_select_n && $past(chip_select_n) |-> $stable(serial_out_line_o))
    else $error("data out moved between frames");
  a_rp_rise: assert property ($rose(read_program_state) |-> command_done)
    else $error("read-program entered without a command");
  a_rp_fall: assert property ($fell(read_program_state) |-> command_done)
    else $error("read-program left without a command");
  c_done: cover property (command_done);
  c_drop: cover property (frame_dropped);
  c_rp: cover property ($rose(read_program_state));
endmodule : pot_chk

bind pot_serial_command_decoder pot_chk pot_chk_i (.clock(clock), .sys_rst(sys_rst),
  .link_clock(link_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
  .wiper_register(wiper_register), .read_program_state(read_program_state),
  .serial_out_line_o(serial_out_line_o), .serial_out_line_oe(serial_out_line_oe),
  .frame_dropped(frame_dropped), .command_done(command_done));

// *** bench/pot_host.sv ***
// Serial controller model on the far side of the decoder
`timescale 1ns/1ps
module pot_host (
  input wire logic sys_rst,
  input wire logic sdo_wire,
  output logic link_clock,
  output logic chip_select_n,
  output logic serial_in
);
  import pot_pkg::*;
  frame_t rx;
  // Edges during reset clear the link counter; the clock then rests low
  initial begin
    link_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    rx = '0;
    wait (sys_rst === 1'b1);
    repeat (8) #7.5 link_clock = ~link_clock;
    // Two rising edges after release drain the link reset synchroniser
    wait (sys_rst === 1'b0);
    repeat (4) #7.5 link_clock = ~link_clock;
  end
  // Setup delay lets the late output enable settle before the first bit
  task automatic send(input frame_t w, input int n);
    chip_select_n = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      rx = {rx[22:0], sdo_wire};
      #7.5 link_clock = 1'b1;
      #7.5 link_clock = 1'b0;
    end
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #140;
  endtask : send
endmodule : pot_host

// *** bench/tb_top.sv ***
// Self-checking bench for the potentiometer command decoder
`timescale 1ns/1ps
module tb_top;
  import pot_pkg::*;
  logic clock, sys_rst, link_clock, chip_select_n, serial_in, sdo_wire;
  logic serial_out_line_o, serial_out_line_oe, frame_dropped, command_done, read_program_state;
  wiper_t wiper_register;
  int miscompares = 0;
  int samples_checked = 0;
  // Released line floats to the pull-up level
  assign sdo_wire = serial_out_line_oe ? serial_out_line_o : 1'b1;
  pot_serial_command_decoder pot_serial_command_decoder_i (.clock(clock), .sys_rst(sys_rst),
    .link_clock(link_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .wiper_register(wiper_register), .read_program_state(read_program_state),
    .serial_out_line_o(serial_out_line_o), .serial_out_line_oe(serial_out_line_oe),
    .frame_dropped(frame_dropped), .command_done(command_done));
  pot_host pot_host_i (.sys_rst(sys_rst), .sdo_wire(sdo_wire), .link_clock(link_clock),
    .chip_select_n(chip_select_n), .serial_in(serial_in));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic run(input frame_t w, input int n, input bit drop);
    fork
      pot_host_i.send(w, n);
      begin
        int k = 0;
        while (k < 60 && (drop ? frame_dropped : command_done) !== 1'b1) begin
          @(negedge clock);
          k++;
        end
        if (k == 60) begin
          miscompares++;
          finish_test();
        end
      end
    join
  endtask : run
  task automatic t_steps();
    logic [33:0] tbl [13] = '{{24'hb003fe, 10'h3fe}, {24'hf5ffff, 10'h3ff},
      {24'he00000, 10'h3ff}, {24'h7a1234, 10'h3fe}, {24'h400000, 10'h1ff},
      {24'h500000, 10'h0ff}, {24'hc00000, 10'h1fe}, {24'hd90000, 10'h3fc},
      {24'hd00000, 10'h3ff}, {24'hb00000, 10'h000}, {24'h600000, 10'h000},
      {24'hc00000, 10'h001}, {24'h5f0000, 10'h000}};
    foreach (tbl[i]) begin
      run(tbl[i][33:10], 24, 1'b0);
      check(wiper_register, tbl[i][9:0]);
    end
  endtask : t_steps
  task automatic t_repeat();
    run(24'hb00155, 24, 1'b0);
    run(24'h700000, 24, 1'b0);
    run(24'h000000, 0, 1'b0);
    check(wiper_register, 24'h153);
  endtask : t_repeat
  task automatic t_store();
    run(24'hb00155, 24, 1'b0);
    run(24'h200000, 24, 1'b0);
    run(24'hb000aa, 24, 1'b0);
    run(24'h8fffff, 24, 1'b0);
    check(wiper_register, 24'h155);
    run(24'hb000aa, 24, 1'b0);
    run(24'h100000, 24, 1'b0);
    check({wiper_register, read_program_state}, {10'h155, 1'b1});
    run(24'h0f1234, 24, 1'b0);
    check({wiper_register, read_program_state}, {10'h155, 1'b0});
  endtask : t_store
  task automatic t_read();
    run(24'h33beef, 24, 1'b0);
    run(24'h930000, 24, 1'b0);
    run(24'h0abcde, 24, 1'b0);
    check(pot_host_i.rx, 24'h93beef);
    run(24'h000000, 24, 1'b0);
    check(pot_host_i.rx, 24'h0abcde);
    run(24'ha00000, 24, 1'b0);
    run(24'h000000, 24, 1'b0);
    check({pot_host_i.rx[23:16], pot_host_i.rx[9:0]}, {8'ha0, 10'h155});
    run(24'h30fc37, 24, 1'b0);
    run(24'h800000, 24, 1'b0);
    check(wiper_register, 24'h037);
  endtask : t_read
  task automatic t_drop();
    run(24'hb00000, 23, 1'b1);
    repeat (3) @(negedge clock);
    check(wiper_register, 24'h037);
    run(24'hb00011, 24, 1'b0);
    check(wiper_register, 24'h011);
    run(24'hb10123, 24, 1'b0);
    check(wiper_register, 24'h011);
  endtask : t_drop
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    repeat (5) @(negedge clock);
    check(wiper_register, 24'h200);
    t_steps();
    t_repeat();
    t_store();
    t_read();
    t_drop();
    finish_test();
  end
endmodule : tb_top
